// ==== verilog/tick_pkg.sv ====
package tick_pkg;
    // Register indices as printed; byte address is four times the index
    localparam logic [13:0] IDX_STATUS_CTRL = 14'h306a;
    localparam logic [13:0] IDX_SRC_DIV = 14'h306b;
    localparam logic [13:0] IDX_LIMIT_HIGH = 14'h306c;
    localparam logic [13:0] IDX_LIMIT_LOW = 14'h306d;
    localparam logic [13:0] IDX_COUNT_HIGH = 14'h306e;
    localparam logic [13:0] IDX_COUNT_LOW = 14'h306f;
    localparam int ADDR_W = 16;

    // Field positions
    localparam int FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 6;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 0;

    // Reset values
    localparam logic [1:0] SRC_RESET = 2'h0;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [15:0] COUNT_ZERO = 16'h0000;

    // Source codes and divider code for off
    localparam logic [1:0] SRC_EXT_OSC = 2'h0;
    localparam logic [1:0] SRC_LPO = 2'h1;
    localparam logic [2:0] DIV_OFF = 3'h0;
    localparam int PRESCALE_W = 11;

    // Prescaler divide ratio for a source select and divider code
    function automatic logic [PRESCALE_W-1:0] divide_ratio(input logic [1:0] src,
                                                          input logic [2:0] div);
        logic [PRESCALE_W-1:0] r;
        r = 11'h001;
        if (!src[0]) begin
            r = PRESCALE_W'(11'h001 << (div - 3'h1));
        end else begin
            case (div)
                3'h6: r = 11'h064;
                3'h7: r = 11'h3e8;
                default: r = PRESCALE_W'(11'h080 << (div - 3'h1));
            endcase
        end
        return r;
    endfunction

    // APB request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } apb_rsp_s;

    // State of the main block
    typedef struct packed {
        logic [1:0] src;
        logic [2:0] div;
        logic irq_en;
        logic flag;
        logic [7:0] limit_high;
        logic [7:0] limit_low;
        logic [15:0] active_limit;
        logic [15:0] count;
        logic [7:0] locked_high;
        logic locked;
        logic ready;
        logic slverr;
        logic [7:0] rdata;
    } tick_state_s;

    typedef struct packed {
        logic last;
    } edge_state_s;

    typedef struct packed {
        logic [PRESCALE_W-1:0] cnt;
    } prescale_state_s;
endpackage

// ==== verilog/rise_detect.sv ====
`timescale 1ns/1ps
module rise_detect
    import tick_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic level,
    output logic rise
);
    edge_state_s st;
    edge_state_s next_st;

    // One-cycle pulse on a low-to-high step of the sampled source
    assign rise = level & ~st.last;

    always_comb begin
        next_st = st;
        next_st.last = level;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== verilog/prescaler.sv ====
`timescale 1ns/1ps
module prescaler
    import tick_pkg::*;
#(
    parameter int WIDTH = PRESCALE_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic src_tick,
    input wire logic clear,
    input wire logic run,
    input wire logic [WIDTH-1:0] ratio,
    output logic tick
);
    prescale_state_s st;
    prescale_state_s next_st;

    initial begin
        if (WIDTH != PRESCALE_W) begin
            $error("prescaler width must match the package");
        end
    end

    // A tick is the last source edge of each divide period
    assign tick = run & ~clear & src_tick & (st.cnt == ratio - WIDTH'(1));

    always_comb begin
        next_st = st;
        if (clear) begin
            next_st.cnt = '0;
        end else if (run && src_tick) begin
            next_st.cnt = tick ? '0 : st.cnt + WIDTH'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== verilog/periodic_tick_counter.sv ====
// Functional notes
// R1: Source 00 external oscillator, 01 1 kHz source, 10 and 11 bus clock.
// R2: Reset sets source select to 00.
// R3: Writing a changed source or divider clears prescaler and counter.
// R4: Divider 000 off; with source x0, 001..111 divide by 1..64.
// R5: With source x1, 001..101 divide 128..2048, 110 by 100, 111 by 1000.
// R6: Reset clears divider select, prescaler off.
// R7: Control bits 5 to 3 read zero and ignore writes.
// R8: Counter equal to the 16-bit limit wraps to zero and sets the flag.
// R9: Limit zero sets the flag on every prescaler tick.
// R10: Reset clears both limit bytes.
// R11: Count bytes are read-only; writes do nothing.
// R12: Low count read locks the high byte until the high byte is read; the code also releases the lock on a restart (R3).
// R13: Reset clears the count.
// R14: Counter steps per prescaler tick; flag sets on limit to zero step.
// R15: Writing 1 clears the flag; writing 0 leaves it.
// R16: Interrupt request while flag and its enable are both set.
// R17: New limit takes effect at the next wrap or nonzero divider write.
// R18: Divider 000 holds counter and prescaler, no ticks.
`timescale 1ns/1ps
module periodic_tick_counter
    import tick_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_osc,
    input wire logic lpo_clk,
    output logic irq
);
    apb_req_s req;
    apb_rsp_s rsp;
    tick_state_s st;
    tick_state_s next_st;
    logic ext_rise;
    logic lpo_rise;
    logic src_tick;
    logic presc_tick;
    logic presc_clear;
    logic run;
    logic [PRESCALE_W-1:0] ratio;
    logic [13:0] idx;
    logic aligned;
    logic mapped;
    logic done;
    logic wr_ctrl;
    logic [1:0] wr_src;
    logic [2:0] wr_div;
    logic [7:0] wbyte;

    // Bus signals gathered for the decode
    assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr,
                   pwdata: pwdata, pstrb: pstrb};
    assign rsp = '{pready: st.ready, pslverr: st.slverr, prdata: {24'h00_0000, st.rdata}};
    assign prdata = rsp.prdata;
    assign pready = rsp.pready;
    assign pslverr = rsp.pslverr;
    assign irq = st.flag & st.irq_en; // see R16

    // Clock sources sampled as pclk-synchronous levels
    rise_detect u_ext_rise (
        .pclk(pclk),
        .presetn(presetn),
        .level(ext_osc),
        .rise(ext_rise)
    );

    rise_detect u_lpo_rise (
        .pclk(pclk),
        .presetn(presetn),
        .level(lpo_clk),
        .rise(lpo_rise)
    );

    // Source selection; both codes with a high bit set take the bus clock
    always_comb begin
        if (st.src == SRC_EXT_OSC) begin
            src_tick = ext_rise; // see R1
        end else if (st.src == SRC_LPO) begin
            src_tick = lpo_rise; // see R1
        end else begin
            src_tick = 1'b1; // see R1
        end
    end

    assign run = (st.div != DIV_OFF); // see R18
    assign ratio = divide_ratio(st.src, st.div); // see R4 see R5

    prescaler #(
        .WIDTH(PRESCALE_W)
    ) u_prescaler (
        .pclk(pclk),
        .presetn(presetn),
        .src_tick(src_tick),
        .clear(presc_clear),
        .run(run),
        .ratio(ratio),
        .tick(presc_tick)
    );

    // Address decode; every access gets one wait state so read data come from a flop
    assign idx = req.paddr[ADDR_W-1:2];
    assign aligned = (req.paddr[1:0] == 2'h0);
    assign mapped = aligned && (idx >= IDX_STATUS_CTRL) && (idx <= IDX_COUNT_LOW);
    assign done = req.psel & req.penable & st.ready;
    assign wbyte = req.pwdata[7:0];
    assign wr_ctrl = done & req.pwrite & mapped & req.pstrb[0] & (idx == IDX_SRC_DIV);
    assign wr_src = wbyte[SRC_HI:SRC_LO];
    assign wr_div = wbyte[DIV_HI:DIV_LO];

    // Only a change of either field restarts the time base
    assign presc_clear = wr_ctrl & ((wr_src != st.src) | (wr_div != st.div)); // see R3

    always_comb begin
        next_st = st;
        next_st.ready = 1'b0;
        next_st.slverr = 1'b0;

        // Access phase: first cycle captures the answer, second cycle completes
        if (req.psel && req.penable && !st.ready) begin
            next_st.ready = 1'b1;
            next_st.slverr = ~mapped;
            next_st.rdata = BYTE_RESET;
            if (!req.pwrite && mapped) begin
                case (idx)
                    IDX_STATUS_CTRL: begin
                        next_st.rdata[FLAG_BIT] = st.flag;
                        next_st.rdata[IRQ_EN_BIT] = st.irq_en;
                    end
                    IDX_SRC_DIV: begin
                        next_st.rdata[SRC_HI:SRC_LO] = st.src;
                        next_st.rdata[DIV_HI:DIV_LO] = st.div; // see R7
                    end
                    IDX_LIMIT_HIGH: next_st.rdata = st.limit_high;
                    IDX_LIMIT_LOW: next_st.rdata = st.limit_low;
                    IDX_COUNT_HIGH: next_st.rdata = st.locked ? st.locked_high
                                                              : st.count[15:8]; // see R12
                    IDX_COUNT_LOW: next_st.rdata = st.count[7:0];
                    default: next_st.rdata = BYTE_RESET;
                endcase
            end
        end

        // Counter advances one step per prescaler tick
        if (presc_tick) begin
            if (st.count == st.active_limit) begin
                next_st.count = COUNT_ZERO; // see R8 see R9 see R14
                next_st.flag = 1'b1; // see R8 see R9 see R14
                next_st.active_limit = {st.limit_high, st.limit_low}; // see R17
            end else begin
                next_st.count = st.count + 16'h0001; // see R14
            end
        end

        // Register side effects take place at the completing edge only
        if (done && mapped && !req.pwrite) begin
            if (idx == IDX_COUNT_LOW) begin
                next_st.locked = 1'b1; // see R12
                next_st.locked_high = st.count[15:8]; // see R12
            end else if (idx == IDX_COUNT_HIGH) begin
                next_st.locked = 1'b0; // see R12
            end
        end

        // Count registers are left out on purpose: writes there do nothing
        if (done && mapped && req.pwrite && req.pstrb[0]) begin // see R11
            case (idx)
                IDX_STATUS_CTRL: begin
                    next_st.irq_en = wbyte[IRQ_EN_BIT];
                    // Clear by one, but a match in this very cycle wins
                    if (wbyte[FLAG_BIT] && !(presc_tick && st.count == st.active_limit)) begin
                        next_st.flag = 1'b0; // see R15
                    end
                end
                IDX_SRC_DIV: begin
                    next_st.src = wr_src; // see R1
                    next_st.div = wr_div; // see R7
                    if (wr_div != DIV_OFF) begin
                        next_st.active_limit = {st.limit_high, st.limit_low}; // see R17
                    end
                end
                IDX_LIMIT_HIGH: next_st.limit_high = wbyte; // see R17
                IDX_LIMIT_LOW: next_st.limit_low = wbyte; // see R17
                default: next_st.locked = st.locked;
            endcase
        end

        // Restart wins over any tick in the same cycle
        if (presc_clear) begin
            next_st.count = COUNT_ZERO; // see R3
            next_st.locked = 1'b0;
        end
    end

    // Reset puts every field to zero: source external, prescaler off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0; // see R2 see R6 see R10 see R13
        end else begin
            st <= next_st;
        end
    end
endmodule

// ==== testbench/tick_checker.sv ====
`timescale 1ns/1ps
module tick_checker
    import tick_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ext_osc,
    input wire logic lpo_clk,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hit;
    // Word-aligned access into the six-register window
    assign hit = paddr[15:2] >= IDX_STATUS_CTRL && paddr[15:2] <= IDX_COUNT_LOW && !paddr[1:0];
    sequence wait_s; psel && penable && !pready; endsequence
    sequence done_s; psel && penable && pready; endsequence
    wait_state_a: assert property (wait_s |=> pready) else $error("no answer");
    first_wait_a: assert property (psel && $rose(penable) |-> !pready) else $error("no wait");
    ready_pulse_a: assert property (pready |=> !pready) else $error("long ready");
    err_ready_a: assert property (pslverr |-> done_s) else $error("stray error");
    err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
    upper_zero_a: assert property ((done_s and !pwrite) |-> !prdata[31:8]) else $error("upper bits");
    map_error_a: assert property (done_s |-> pslverr == !hit) else $error("decode");
    reserved_bits_a: assert property ((done_s and (!pwrite && paddr[15:2] == IDX_SRC_DIV)) |->
        !prdata[5:3]) else $error("reserved bits");
    irq_mask_a: assert property ((done_s and (pwrite && pstrb[0] && paddr == {IDX_STATUS_CTRL,
        2'b00} && !pwdata[6])) |=> !irq) else $error("masked irq");
endmodule
bind periodic_tick_counter tick_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc),
    .lpo_clk(lpo_clk), .irq(irq));

// ==== testbench/tb.sv ====
`timescale 1ns/1ps
module tb;
    import tick_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic ext_osc = 0, lpo_clk = 0, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, v1, v2, rnd;
    logic [3:0] pstrb = 4'hf;
    logic [33:0] notes[$], e;
    int miscompares = 0, num_checks = 0, cyc = 0, k, per, s, d;
    periodic_tick_counter uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_osc(ext_osc), .lpo_clk(lpo_clk), .irq(irq));
    // Clock
    initial begin
        forever #10 pclk = ~pclk;
    end
    // Slow sources, periods 6 and 4 cycles so every level step is sampled
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        ext_osc <= (cyc % 6) < 3;
        lpo_clk <= (cyc % 4) < 2;
    end
    task chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Reads pop the oldest note; notes without bit 33 are raw reads
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && notes.size() > 0) begin
            e = notes.pop_front();
            if (e[33])
                chk({pslverr, prdata}, e[32:0]);
        end
    end
    // One transfer; request held until pready is sampled high
    task xfer(input logic w, input logic [13:0] i, input logic [31:0] dt,
              input logic [33:0] ex, output logic [31:0] r);
        @(posedge pclk);
        if (!w)
            notes.push_back(ex);
        psel <= 1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        psel <= 0;
        penable <= 0;
    endtask
    task wr(input logic [13:0] i, input logic [7:0] dt);
        xfer(1, i, {24'h0, dt}, '0, v2);
    endtask
    task rd(input logic [13:0] i, input logic [8:0] ex);
        xfer(0, i, '0, {1'b1, ex[8], 24'h0, ex[7:0]}, v1);
    endtask
    // Looked at mid-cycle, after the write edge has landed
    task ichk(input logic ex);
        @(negedge pclk);
        chk({32'h0, irq}, {32'h0, ex});
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Watchdog, well past the longest divider sweep
    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        final_report;
    end
    initial begin
        rnd = $urandom(32'hf6b8c665);
        repeat (5) @(posedge pclk);
        presetn <= 1;
        for (k = 0; k < 6; k++)
            rd(14'(IDX_STATUS_CTRL + k), 9'h000);
        rd(14'h0, 9'h100);
        wr(IDX_SRC_DIV, 8'hff);
        rd(IDX_SRC_DIV, 9'h0c7);
        wr(IDX_SRC_DIV, 8'h81);
        repeat (6) @(posedge pclk);
        wr(IDX_SRC_DIV, 8'h80);
        rd(IDX_COUNT_LOW, 9'h000);
        wr(IDX_COUNT_LOW, 8'hff);
        wr(IDX_COUNT_HIGH, 8'hff);
        rd(IDX_COUNT_LOW, 9'h000);
        rd(IDX_COUNT_HIGH, 9'h000);
        rnd = $urandom;
        wr(IDX_LIMIT_HIGH, 8'hff);
        wr(IDX_LIMIT_LOW, rnd[7:0]);
        rd(IDX_LIMIT_LOW, {1'b0, rnd[7:0]});
        rd(IDX_LIMIT_HIGH, 9'h0ff);
        // Any span of k periods holds k ticks, whatever the phase
        for (s = 0; s < 4; s++) begin
            for (d = 1; d < 8; d++) begin
                per = (s == 0) ? 6 : (s == 1) ? 4 : 1;
                per *= !s[0] ? (1 << (d - 1)) : (d == 6) ? 100 : (d == 7) ? 1000 : 128 << (d - 1);
                k = (per < 4) ? 4 : 1;
                wr(IDX_SRC_DIV, {s[1:0], 3'b000, d[2:0]});
                xfer(0, IDX_COUNT_LOW, '0, '0, v1);
                repeat (k * per - 4) @(posedge pclk);
                xfer(0, IDX_COUNT_LOW, '0, '0, v2);
                chk({25'h0, v2[7:0] - v1[7:0]}, 33'(k));
            end
        end
        wr(IDX_SRC_DIV, 8'h81);
        xfer(0, IDX_COUNT_LOW, '0, '0, v1);
        repeat (600) @(posedge pclk);
        rd(IDX_COUNT_HIGH, 9'h000);
        wr(IDX_LIMIT_HIGH, 8'h00);
        wr(IDX_LIMIT_LOW, 8'h03);
        wr(IDX_SRC_DIV, 8'h80);
        wr(IDX_STATUS_CTRL, 8'hc0);
        wr(IDX_SRC_DIV, 8'h81);
        ichk(0);
        repeat (10) @(posedge pclk);
        ichk(1);
        wr(IDX_SRC_DIV, 8'h80);
        wr(IDX_STATUS_CTRL, 8'h40);
        ichk(1);
        wr(IDX_STATUS_CTRL, 8'hc0);
        ichk(0);
        rd(IDX_STATUS_CTRL, 9'h040);
        wr(IDX_LIMIT_LOW, 8'h00);
        wr(IDX_SRC_DIV, 8'h87);
        repeat (80) @(posedge pclk);
        ichk(1);
        wr(IDX_STATUS_CTRL, 8'h00);
        ichk(0);
        rd(IDX_STATUS_CTRL, 9'h080);
        final_report;
    end
endmodule
